//--- hw/cgdm_pkg.sv
package cgdm_pkg;

  // Register offsets on the plain register port.
  localparam logic [2:0] CGDM_OFS_CTRL_ONE   = 3'h0;
  localparam logic [2:0] CGDM_OFS_CTRL_TWO   = 3'h1;
  localparam logic [2:0] CGDM_OFS_STATUS     = 3'h2;
  localparam logic [2:0] CGDM_OFS_CTRL_THREE = 3'h3;
  localparam logic [2:0] CGDM_OFS_TEST_CTRL  = 3'h4;
  localparam logic [2:0] CGDM_OFS_DIVIDERS   = 3'h5;

  // Field positions of control register one.
  localparam int CGDM_C1_CLOCK_SOURCE_SELECT_HI = 7;
  localparam int CGDM_C1_CLOCK_SOURCE_SELECT_LO = 6;
  localparam int CGDM_C1_REF_DIVIDER_FIELD_HI = 5;
  localparam int CGDM_C1_REF_DIVIDER_FIELD_LO = 3;

  // Field positions of control register two.
  localparam int CGDM_C2_RANGE = 5;
  localparam int CGDM_C2_LP    = 3;

  // Field positions of control register three.
  localparam int CGDM_C3_PLL_FLL_SELECT    = 6;
  localparam int CGDM_C3_EXTRA_DIVIDE_BY_THIRTYTWO   = 4;
  localparam int CGDM_C3_VCO_DIVIDER_FIELD_HI = 3;
  localparam int CGDM_C3_VCO_DIVIDER_FIELD_LO = 0;

  // Field positions of the status register.
  localparam int CGDM_SC_LOCK     = 6;
  localparam int CGDM_SC_PLL_FLL_SELECT_STATUS    = 5;
  localparam int CGDM_SC_CLOCK_SOURCE_STATUS_HI = 3;
  localparam int CGDM_SC_CLOCK_SOURCE_STATUS_LO = 2;

  // Field positions of the test and control register.
  localparam int CGDM_TC_DCO_MAX_FINETUNE = 5;
  localparam int CGDM_TC_DRS   = 0;

  // Values after reset.
  localparam logic [7:0] CGDM_RST_CTRL_ONE   = 8'h04;
  localparam logic [7:0] CGDM_RST_CTRL_TWO   = 8'h40;
  localparam logic [7:0] CGDM_RST_CTRL_THREE = 8'h01;
  localparam logic [7:0] CGDM_RST_TEST_CTRL  = 8'h00;

  // Masks of writable bits; test bits 7:6 and 4:1 are held at zero.
  localparam logic [7:0] CGDM_TC_WMASK = 8'h21;

  // Clock source codes.
  localparam logic [1:0] CGDM_SRC_FLLPLL = 2'h0;
  localparam logic [1:0] CGDM_SRC_INT    = 2'h1;
  localparam logic [1:0] CGDM_SRC_EXT    = 2'h2;

  // FLL multiplication factors.
  localparam logic [10:0] CGDM_FLL_LOW    = 11'h200;
  localparam logic [10:0] CGDM_FLL_LOW_FT = 11'h260;
  localparam logic [10:0] CGDM_FLL_MID    = 11'h400;
  localparam logic [10:0] CGDM_FLL_MID_FT = 11'h4C0;

  // Synchroniser depth and lock settle time.
  localparam int CGDM_SYNC_STAGES = 2;
  localparam int CGDM_LOCK_NS     = 1000;
  localparam int CGDM_CLK_NS      = 10;
  localparam int CGDM_LOCK_CYC    = (CGDM_LOCK_NS + CGDM_CLK_NS - 1)
                                    / CGDM_CLK_NS;

  // Operating modes of the generator.
  typedef enum logic [6:0] {
    CGDM_FEI  = 7'h01,
    CGDM_FBI  = 7'h02,
    CGDM_BYPASS_LOWPOWER_INT = 7'h04,
    CGDM_FBE  = 7'h08,
    CGDM_BYPASS_LOWPOWER_EXT = 7'h10,
    CGDM_PBE  = 7'h20,
    CGDM_PEE  = 7'h40
  } cgdm_mode_t;

endpackage

//--- hw/cgdm_sync.sv
module cgdm_sync
  import cgdm_pkg::*;
#(
  parameter int WIDTH = 4
) (
  // Clock and reset.
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  // Value in the source domain and its settled copy.
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;

  // Two stages; only the second stage reads the first.
  always_comb begin
    meta_nxt = d_in;
    q_nxt    = meta_r;
  end

  // The stages clear on reset so that status starts from a known value.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end

  assign q_out = q_r;

endmodule

//--- hw/cgdm_lock.sv
module cgdm_lock
  import cgdm_pkg::*;
#(
  parameter int CYCLES = CGDM_LOCK_CYC
) (
  // Clock and reset.
  input  wire logic clock_in,
  input  wire logic rst_in,
  // Loop running and its settings changed.
  input  wire logic run_in,
  input  wire logic restart_in,
  // Lock reached.
  output logic      lock_out
);

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        lock_r;
  logic        lock_nxt;

  // A restart request or a stopped loop clears the settle count, since the loop
  // must reacquire before its output can be trusted.
  always_comb begin
    cnt_nxt  = cnt_r;
    lock_nxt = lock_r;
    if (!run_in || restart_in) begin
      cnt_nxt  = 16'h0000;
      lock_nxt = 1'b0;
    end else if (cnt_r == 16'(CYCLES - 1)) begin
      lock_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end

  // Registered count and lock flag.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cnt_r  <= 16'h0000;
      lock_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      lock_r <= lock_nxt;
    end
  end

  assign lock_out = lock_r;

endmodule

//--- hw/cgdm_top.sv
// Behaviour
// - FLL divide: power of two, times 32 when range and divide-by-32 are both set
// - PLL divide equals two to field
// - Fine-tune bit picks narrowed DCO range
// - Range status follows select after synchronisation
// - Range status zero in listed modes
// - Range writes ignored while LP/PLL_FLL_SELECT set
// - Range select: zero low, one mid
// - FLL factor 512/608/1024/1216
// - External select reported after synchronisation
// - Code 01 selects internal reference clock
// - PLL_FLL_SELECT clear selects FLL, status clears
// - Divide-by-32 switches to FLL divider
// - LP bit toggles BYPASS_LOWPOWER_EXT and FBE/PBE
// - Lock flag; FLL runs in FBE
// - VCO field ignored while FLL selected
// - PLL_FLL_SELECT change in BYPASS_LOWPOWER_EXT keeps output
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
module cgdm_top
  import cgdm_pkg::*;
#(
  parameter int LOCK_CYCLES = CGDM_LOCK_CYC
) (
  // Clock and reset.
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  // Register port.
  input  wire logic [2:0]        addr_in,
  input  wire logic [7:0]        wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [7:0]        rdata_out,
  // Derived clock configuration.
  output cgdm_pkg::cgdm_mode_t   mode_out,
  output logic      [10:0]       fll_ref_div_out,
  output logic      [7:0]        pll_ref_div_out,
  output logic      [10:0]       fll_factor_out,
  output logic      [3:0]        vco_div_out,
  output logic                   div_reserved_out,
  output logic      [1:0]        clock_source_status_out,
  output logic                   fll_running_out,
  output logic                   pll_running_out
);

  logic [7:0]  ctrl_one_r;
  logic [7:0]  ctrl_one_nxt;
  logic [7:0]  ctrl_two_r;
  logic [7:0]  ctrl_two_nxt;
  logic [7:0]  ctrl_three_r;
  logic [7:0]  ctrl_three_nxt;
  logic [7:0]  test_ctrl_r;
  logic [7:0]  test_ctrl_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  logic [1:0]  clock_source_select;
  logic [2:0]  ref_divider_field;
  logic        low_power_bypass;
  logic        pll_fll_select;
  logic        extra_divide_by_thirtytwo;
  logic        dco_max_finetune;
  logic        dco_range_select;
  logic        range_bit;
  logic [3:0]  vco_divider_field;
  logic [3:0]  sync_d;
  logic [3:0]  sync_q;
  logic [1:0]  clock_source_status;
  logic        pll_fll_select_status;
  logic        dco_range_status;
  logic        lock_raw;
  logic        lock_restart;
  logic        fll_run;
  logic        pll_run;
  cgdm_mode_t  mode;
  logic [7:0]  status_rd;
  logic [7:0]  divs_rd;

  // Two to the power of a three-bit field.
  function automatic logic [7:0] cgdm_pow2(input logic [2:0] f);
    cgdm_pow2 = 8'h01 << f;
  endfunction

  // Field views of the control registers.
  assign clock_source_select       = ctrl_one_r[CGDM_C1_CLOCK_SOURCE_SELECT_HI:
                                                CGDM_C1_CLOCK_SOURCE_SELECT_LO];
  assign ref_divider_field         = ctrl_one_r[CGDM_C1_REF_DIVIDER_FIELD_HI:
                                                CGDM_C1_REF_DIVIDER_FIELD_LO];
  assign range_bit                 = ctrl_two_r[CGDM_C2_RANGE];
  assign low_power_bypass          = ctrl_two_r[CGDM_C2_LP];
  assign pll_fll_select            = ctrl_three_r[CGDM_C3_PLL_FLL_SELECT];
  assign extra_divide_by_thirtytwo = ctrl_three_r[CGDM_C3_EXTRA_DIVIDE_BY_THIRTYTWO];
  assign vco_divider_field         = ctrl_three_r[CGDM_C3_VCO_DIVIDER_FIELD_HI:
                                                  CGDM_C3_VCO_DIVIDER_FIELD_LO];
  assign dco_max_finetune          = test_ctrl_r[CGDM_TC_DCO_MAX_FINETUNE];
  assign dco_range_select          = test_ctrl_r[CGDM_TC_DRS];

  // Register writes. Test bits are masked so stray ones cannot reach
  // the analog trim, even though software should never write them.
  always_comb begin
    ctrl_one_nxt   = ctrl_one_r;
    ctrl_two_nxt   = ctrl_two_r;
    ctrl_three_nxt = ctrl_three_r;
    test_ctrl_nxt  = test_ctrl_r;
    if (wr_in) begin
      case (addr_in)
        CGDM_OFS_CTRL_ONE:   ctrl_one_nxt   = wdata_in;
        CGDM_OFS_CTRL_TWO:   ctrl_two_nxt   = wdata_in;
        CGDM_OFS_CTRL_THREE: ctrl_three_nxt = wdata_in;
        CGDM_OFS_TEST_CTRL: begin
          test_ctrl_nxt[CGDM_TC_DCO_MAX_FINETUNE] = wdata_in[CGDM_TC_DCO_MAX_FINETUNE];
          if (!low_power_bypass && !pll_fll_select) begin
            test_ctrl_nxt[CGDM_TC_DRS] = wdata_in[CGDM_TC_DRS];
          end
          test_ctrl_nxt = test_ctrl_nxt & CGDM_TC_WMASK;
        end
        default: ;
      endcase
    end
  end

  // Mode follows the source select, loop select and low-power bit.
  always_comb begin
    case (clock_source_select)
      CGDM_SRC_FLLPLL: mode = pll_fll_select ? CGDM_PEE : CGDM_FEI;
      CGDM_SRC_INT:    mode = low_power_bypass ? CGDM_BYPASS_LOWPOWER_INT : CGDM_FBI;
      CGDM_SRC_EXT: begin
        if (low_power_bypass) begin
          mode = CGDM_BYPASS_LOWPOWER_EXT;
        end else if (pll_fll_select) begin
          mode = CGDM_PBE;
        end else begin
          mode = CGDM_FBE;
        end
      end
      default: mode = CGDM_FEI;
    endcase
  end

  // The loop is powered except in low-power bypass. In BYPASS_LOWPOWER_EXT the select
  // bit only prepares the next loop, so neither run flag moves.
  always_comb begin
    fll_run = !low_power_bypass && !pll_fll_select;
    pll_run = !low_power_bypass && pll_fll_select;
  end

  // Reference dividers and FLL multiplier.
  always_comb begin
    pll_ref_div_out  = cgdm_pow2(ref_divider_field);
    fll_ref_div_out  = {3'h0, cgdm_pow2(ref_divider_field)};
    div_reserved_out = 1'b0;
    if (range_bit && extra_divide_by_thirtytwo) begin
      fll_ref_div_out  = {cgdm_pow2(ref_divider_field), 3'h0} << 2;
      div_reserved_out = ref_divider_field[2] & ref_divider_field[1];
    end
    case ({dco_range_select, dco_max_finetune})
      2'h0:    fll_factor_out = CGDM_FLL_LOW;
      2'h1:    fll_factor_out = CGDM_FLL_LOW_FT;
      2'h2:    fll_factor_out = CGDM_FLL_MID;
      2'h3:    fll_factor_out = CGDM_FLL_MID_FT;
      default: fll_factor_out = CGDM_FLL_LOW;
    endcase
    vco_div_out = pll_fll_select ? vco_divider_field : 4'h0;
  end

  // Selections pass into the generator's domain before status shows
  // them; this costs two cycles of latency but avoids torn reads.
  assign sync_d = {clock_source_select, pll_fll_select, dco_range_select};

  cgdm_sync #(
    .WIDTH (4)
  ) u_sync (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .d_in     (sync_d),
    .q_out    (sync_q)
  );

  // Status fields come from the synchronised copies; range status is zeroed by the current mode.
  always_comb begin
    clock_source_status   = sync_q[3:2];
    pll_fll_select_status = sync_q[1];
    dco_range_status      = sync_q[0];
    if (mode == CGDM_BYPASS_LOWPOWER_INT || mode == CGDM_BYPASS_LOWPOWER_EXT ||
        mode == CGDM_PBE || mode == CGDM_PEE) begin
      dco_range_status = 1'b0;
    end
  end

  // A write to control register three or the test register restarts lock acquisition.
  assign lock_restart = wr_in && (addr_in == CGDM_OFS_CTRL_THREE ||
                                  addr_in == CGDM_OFS_TEST_CTRL);

  cgdm_lock #(
    .CYCLES (LOCK_CYCLES)
  ) u_lock (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .run_in     (fll_run || pll_run),
    .restart_in (lock_restart),
    .lock_out   (lock_raw)
  );

  // Read views of status and of the divider summary.
  always_comb begin
    status_rd = 8'h00;
    status_rd[CGDM_SC_LOCK] = lock_raw;
    status_rd[CGDM_SC_PLL_FLL_SELECT_STATUS] = pll_fll_select_status;
    status_rd[CGDM_SC_CLOCK_SOURCE_STATUS_HI:CGDM_SC_CLOCK_SOURCE_STATUS_LO] = clock_source_status;
    divs_rd = {div_reserved_out, ref_divider_field, vco_div_out};
  end

  // Read data for the cycle after the strobe; unmapped reads give zero.
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd_in) begin
      case (addr_in)
        CGDM_OFS_CTRL_ONE:   rdata_nxt = ctrl_one_r;
        CGDM_OFS_CTRL_TWO:   rdata_nxt = ctrl_two_r;
        CGDM_OFS_STATUS:     rdata_nxt = status_rd;
        CGDM_OFS_CTRL_THREE: rdata_nxt = ctrl_three_r;
        CGDM_OFS_TEST_CTRL: begin
          rdata_nxt = test_ctrl_r;
          rdata_nxt[CGDM_TC_DRS] = dco_range_status;
        end
        CGDM_OFS_DIVIDERS:   rdata_nxt = divs_rd;
        default:             rdata_nxt = 8'h00;
      endcase
    end
  end

  // State registers.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ctrl_one_r   <= CGDM_RST_CTRL_ONE;
      ctrl_two_r   <= CGDM_RST_CTRL_TWO;
      ctrl_three_r <= CGDM_RST_CTRL_THREE;
      test_ctrl_r  <= CGDM_RST_TEST_CTRL;
      rdata_r      <= 8'h00;
    end else begin
      ctrl_one_r   <= ctrl_one_nxt;
      ctrl_two_r   <= ctrl_two_nxt;
      ctrl_three_r <= ctrl_three_nxt;
      test_ctrl_r  <= test_ctrl_nxt;
      rdata_r      <= rdata_nxt;
    end
  end

  // Outputs.
  assign rdata_out               = rdata_r;
  assign mode_out                = mode;
  assign clock_source_status_out = clock_source_status;
  assign fll_running_out         = fll_run;
  assign pll_running_out         = pll_run;

endmodule

//--- testbench/cgdm_top_sva.sv
module cgdm_top_sva
  import cgdm_pkg::*;
#(
  parameter int LOCK_CYCLES = CGDM_LOCK_CYC
) (
  // Clock and reset.
  input wire logic        clock_in,
  input wire logic        rst_in,
  // Register port.
  input wire logic [2:0]  addr_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  rdata_out,
  // Derived clock configuration.
  input cgdm_mode_t       mode_out,
  input wire logic [10:0] fll_ref_div_out,
  input wire logic [7:0]  pll_ref_div_out,
  input wire logic [10:0] fll_factor_out,
  input wire logic [3:0]  vco_div_out,
  input wire logic        div_reserved_out,
  input wire logic [1:0]  clock_source_status_out,
  input wire logic        fll_running_out,
  input wire logic        pll_running_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  c1_r, c2_r, c3_r;
  logic        drs_r, dmx_r, pll_p1_r, pll_p2_r;
  logic [1:0]  src_p1_r, src_p2_r;
  logic [10:0] exp_fac;
  cgdm_mode_t  exp_mode;

  // Shadow the control bits from the strobes so that no internal signal
  // is needed; the sync pipes mirror the two-stage settling delay.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      c1_r     <= CGDM_RST_CTRL_ONE;
      c2_r     <= CGDM_RST_CTRL_TWO;
      c3_r     <= CGDM_RST_CTRL_THREE;
      {drs_r, dmx_r, pll_p1_r, pll_p2_r} <= 4'h0;
      {src_p1_r, src_p2_r} <= 4'h0;
    end else begin
      if (wr_in && addr_in == CGDM_OFS_CTRL_ONE) c1_r <= wdata_in;
      if (wr_in && addr_in == CGDM_OFS_CTRL_TWO) c2_r <= wdata_in;
      if (wr_in && addr_in == CGDM_OFS_CTRL_THREE) c3_r <= wdata_in;
      if (wr_in && addr_in == CGDM_OFS_TEST_CTRL) begin
        dmx_r <= wdata_in[CGDM_TC_DCO_MAX_FINETUNE];
        if (!c2_r[CGDM_C2_LP] && !c3_r[CGDM_C3_PLL_FLL_SELECT]) drs_r <= wdata_in[0];
      end
      src_p1_r <= c1_r[7:6];
      src_p2_r <= src_p1_r;
      pll_p1_r <= c3_r[CGDM_C3_PLL_FLL_SELECT];
      pll_p2_r <= pll_p1_r;
    end
  end

  // Expected factor and mode from the shadowed settings.
  assign exp_fac = drs_r ? (dmx_r ? 11'h4C0 : 11'h400)
                         : (dmx_r ? 11'h260 : 11'h200);
  assign exp_mode = (c1_r[7:6] == CGDM_SRC_INT) ?
                    (c2_r[3] ? CGDM_BYPASS_LOWPOWER_INT : CGDM_FBI) :
                    (c1_r[7:6] == CGDM_SRC_EXT) ?
                    (c2_r[3] ? CGDM_BYPASS_LOWPOWER_EXT : c3_r[6] ? CGDM_PBE : CGDM_FBE) :
                    (c3_r[6] ? CGDM_PEE : CGDM_FEI);

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_pll_div_pow: assert property (
    pll_ref_div_out == (8'h01 << c1_r[5:3])) else $error("pll divide");
  a_fll_div_pow: assert property (!div_reserved_out |->
    fll_ref_div_out == ((c2_r[5] && c3_r[4] ? 11'h020 : 11'h001)
    << c1_r[5:3])) else $error("fll divide");
  a_div_reserved: assert property (div_reserved_out ==
    (c2_r[5] && c3_r[4] && c1_r[5:4] == 2'h3)) else $error("reserved");
  a_fll_factor: assert property (
    fll_factor_out == exp_fac) else $error("fll factor");
  a_mode_decode: assert property (
    mode_out == exp_mode) else $error("mode decode");
  a_vco_masked: assert property (
    vco_div_out == (c3_r[6] ? c3_r[3:0] : 4'h0)) else $error("vco field");
  a_src_synced: assert property (
    clock_source_status_out == src_p2_r) else $error("source status");
  a_status_read: assert property (rd_in && addr_in == 3'h2 |=>
    rdata_out[5] == $past(pll_p2_r) && rdata_out[3:2] == $past(src_p2_r))
    else $error("status read");
  a_range_masked: assert property (rd_in && addr_in == 3'h4 &&
    mode_out inside {CGDM_BYPASS_LOWPOWER_INT, CGDM_BYPASS_LOWPOWER_EXT, CGDM_PBE, CGDM_PEE} |=>
    (rdata_out & 8'hDF) == 8'h00) else $error("range status");
  a_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("rdata idle");
  a_fll_runs_fbe: assert property (
    mode_out == CGDM_FBE |-> fll_running_out) else $error("fll stopped");
endmodule

bind cgdm_top cgdm_top_sva #(.LOCK_CYCLES(LOCK_CYCLES)) u_sva (
  .clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .mode_out(mode_out),
  .fll_ref_div_out(fll_ref_div_out), .pll_ref_div_out(pll_ref_div_out),
  .fll_factor_out(fll_factor_out), .vco_div_out(vco_div_out),
  .div_reserved_out(div_reserved_out),
  .clock_source_status_out(clock_source_status_out),
  .fll_running_out(fll_running_out), .pll_running_out(pll_running_out));

//--- testbench/tb_top.sv
`define CHK(n, e, g) chk(n, 11'(e), 11'(g))

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cgdm_pkg::*;
  logic        clock_in = 1'b0;
  logic        rst_in   = 1'b1;
  logic [2:0]  addr_in  = 3'h0;
  logic [7:0]  wdata_in = 8'h00;
  logic        wr_in    = 1'b0;
  logic        rd_in    = 1'b0;
  logic [7:0]  rdata_out, pll_ref_div_out;
  logic [10:0] fll_ref_div_out, fll_factor_out;
  logic [3:0]  vco_div_out;
  logic [1:0]  clock_source_status_out;
  logic        div_reserved_out, fll_running_out, pll_running_out;
  cgdm_mode_t  mode_out;
  int          n_checks, n_mismatch;

  // A short lock count keeps the polls brief.
  cgdm_top #(.LOCK_CYCLES(4)) uut (
    .clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .mode_out(mode_out),
    .fll_ref_div_out(fll_ref_div_out), .pll_ref_div_out(pll_ref_div_out),
    .fll_factor_out(fll_factor_out), .vco_div_out(vco_div_out),
    .div_reserved_out(div_reserved_out),
    .clock_source_status_out(clock_source_status_out),
    .fll_running_out(fll_running_out), .pll_running_out(pll_running_out));

  // Free running 100 MHz clock.
  always #5 clock_in = ~clock_in;

  task automatic chk(string n, logic [10:0] e, logic [10:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Bus cycles; each returns just after its edge so outputs have settled.
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clock_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clock_in);
    wr_in    <= 1'b0;
    #1;
  endtask

  task automatic rd(logic [2:0] a, output logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clock_in);
    rd_in   <= 1'b0;
    #1;
    d = rdata_out;
  endtask

  // Status polling is bounded; running out ends the run.
  task automatic poll(string n, logic [7:0] m, logic [7:0] v);
    logic [7:0] d;
    for (int i = 0; i < 40; i++) begin
      rd(CGDM_OFS_STATUS, d);
      if ((d & m) === v) break;
    end
    `CHK(n, v, d & m);
    if ((d & m) !== v) summarize();
  endtask

  task automatic t_reset();
    logic [7:0] d;
    logic [2:0] a [5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h6};
    logic [7:0] v [5] = '{8'h04, 8'h40, 8'h01, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin
      rd(a[i], d);
      `CHK("reset value", v[i], d);
    end
    `CHK("reset mode", CGDM_FEI, mode_out);
  endtask

  task automatic t_factor();
    logic [7:0]  d;
    logic [10:0] f [4] = '{11'h200, 11'h260, 11'h400, 11'h4C0};
    for (int i = 0; i < 4; i++) begin
      wr(CGDM_OFS_TEST_CTRL, {2'h0, i[0], 4'h0, i[1]});
      `CHK("fll factor", f[i], fll_factor_out);
    end
    wr(CGDM_OFS_TEST_CTRL, 8'hFF);
    repeat (4) @(posedge clock_in);
    rd(CGDM_OFS_TEST_CTRL, d);
    `CHK("test ctrl", 8'h21, d);
  endtask

  // Range writes must bounce while either bypass control is set.
  task automatic t_ignore();
    wr(CGDM_OFS_CTRL_TWO, 8'h48);
    wr(CGDM_OFS_TEST_CTRL, 8'h00);
    `CHK("range under lp", 11'h400, fll_factor_out);
    wr(CGDM_OFS_CTRL_TWO, 8'h40);
    wr(CGDM_OFS_CTRL_THREE, 8'h51);
    wr(CGDM_OFS_TEST_CTRL, 8'h20);
    `CHK("range under pll", 11'h4C0, fll_factor_out);
    wr(CGDM_OFS_CTRL_THREE, 8'h01);
    wr(CGDM_OFS_TEST_CTRL, 8'h00);
    `CHK("range low", 11'h200, fll_factor_out);
    wr(CGDM_OFS_TEST_CTRL, 8'h01);
    `CHK("range taken", 11'h400, fll_factor_out);
  endtask

  task automatic t_divs();
    for (int r = 0; r < 8; r++) begin
      wr(CGDM_OFS_CTRL_ONE, {2'h0, r[2:0], 3'h0});
      `CHK("pll div", 8'h01 << r, pll_ref_div_out);
      `CHK("fll div", 11'h001 << r, fll_ref_div_out);
    end
    wr(CGDM_OFS_CTRL_TWO, 8'h60);
    wr(CGDM_OFS_CTRL_THREE, 8'h11);
    for (int r = 0; r < 8; r++) begin
      wr(CGDM_OFS_CTRL_ONE, {2'h0, r[2:0], 3'h0});
      `CHK("pll extra_divide_by_thirtytwo", 8'h01 << r, pll_ref_div_out);
      `CHK("reserved", r > 5, div_reserved_out);
      if (r < 6) `CHK("fll extra_divide_by_thirtytwo", 11'h020 << r, fll_ref_div_out);
    end
  endtask

  // Walk from engaged PLL down to low-power internal bypass.
  task automatic t_modes();
    logic [7:0] d;
    wr(CGDM_OFS_CTRL_TWO, 8'h40);
    wr(CGDM_OFS_CTRL_THREE, 8'h51);
    `CHK("mode pee", CGDM_PEE, mode_out);
    `CHK("vco pll", 4'h1, vco_div_out);
    wr(CGDM_OFS_CTRL_ONE, 8'h98);
    `CHK("mode pbe", CGDM_PBE, mode_out);
    poll("ext status", 8'h2C, 8'h28);
    `CHK("src port", CGDM_SRC_EXT, clock_source_status_out);
    rd(CGDM_OFS_TEST_CTRL, d);
    `CHK("range pbe", 8'h00, d);
    wr(CGDM_OFS_CTRL_TWO, 8'h48);
    `CHK("mode bypass_lowpower_ext", CGDM_BYPASS_LOWPOWER_EXT, mode_out);
    wr(CGDM_OFS_CTRL_THREE, 8'h11);
    `CHK("bypass_lowpower_ext held", CGDM_BYPASS_LOWPOWER_EXT, mode_out);
    wr(CGDM_OFS_CTRL_TWO, 8'h40);
    `CHK("mode fbe", CGDM_FBE, mode_out);
    `CHK("fll runs", 1'b1, fll_running_out);
    `CHK("vco fll", 4'h0, vco_div_out);
    poll("fll lock", 8'h60, 8'h40);
    rd(CGDM_OFS_TEST_CTRL, d);
    `CHK("range fbe", 8'h01, d);
    wr(CGDM_OFS_CTRL_ONE, 8'h58);
    `CHK("mode fbi", CGDM_FBI, mode_out);
    poll("int status", 8'h0C, 8'h04);
    wr(CGDM_OFS_CTRL_TWO, 8'h48);
    `CHK("mode bypass_lowpower_int", CGDM_BYPASS_LOWPOWER_INT, mode_out);
    rd(CGDM_OFS_TEST_CTRL, d);
    `CHK("range bypass_lowpower_int", 8'h00, d);
  endtask

  // Watchdog against a hang anywhere in the sequence.
  initial begin
    repeat (20000) @(posedge clock_in);
    n_mismatch++;
    summarize();
  end

  // Main sequence after two cycles of reset.
  initial begin
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    t_reset();
    t_factor();
    t_ignore();
    t_divs();
    t_modes();
    summarize();
  end
endmodule
